// >>> src/cfe_pkg.sv
package cfe_pkg;

  localparam int REG_COUNT = 32;
  localparam int SEL_W     = 5;
  localparam int ADDR_W    = 16;
  localparam int DISP_W    = 6;
  localparam int OP_W      = 5;

  // Status register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0]        STATUS_RESET = 8'h00;
  localparam logic [7:0]        REG_RESET    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET   = 16'h0000;
  localparam logic [ADDR_W-1:0] PTR_STEP     = 16'h0001;

  // Pointer pair select codes and low byte index of each pair
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [SEL_W-1:0] PTR_X_LO = 5'h1a;
  localparam logic [SEL_W-1:0] PTR_Y_LO = 5'h1c;
  localparam logic [SEL_W-1:0] PTR_Z_LO = 5'h1e;

  // Operation codes
  localparam logic [OP_W-1:0] OP_NOP                  = 5'h00;
  localparam logic [OP_W-1:0] OP_BIT_TO_TRANSFER_FLAG = 5'h01;
  localparam logic [OP_W-1:0] OP_TRANSFER_FLAG_TO_BIT = 5'h02;
  localparam logic [OP_W-1:0] OP_FLAG_SET             = 5'h03;
  localparam logic [OP_W-1:0] OP_FLAG_CLEAR           = 5'h04;
  localparam logic [OP_W-1:0] OP_SET_SIGN_FLAG        = 5'h05;
  localparam logic [OP_W-1:0] OP_CLEAR_SIGN_FLAG      = 5'h06;
  localparam logic [OP_W-1:0] OP_SET_OVERFLOW         = 5'h07;
  localparam logic [OP_W-1:0] OP_CLEAR_OVERFLOW       = 5'h08;
  localparam logic [OP_W-1:0] OP_SET_HALF_CARRY       = 5'h09;
  localparam logic [OP_W-1:0] OP_CLEAR_HALF_CARRY     = 5'h0a;
  localparam logic [OP_W-1:0] OP_REGISTER_MOVE        = 5'h0b;
  localparam logic [OP_W-1:0] OP_REGISTER_PAIR_COPY   = 5'h0c;
  localparam logic [OP_W-1:0] OP_IMMEDIATE_LOAD       = 5'h0d;
  localparam logic [OP_W-1:0] OP_INDIRECT_LOAD        = 5'h0e;
  localparam logic [OP_W-1:0] OP_INDIRECT_LOAD_INC    = 5'h0f;
  localparam logic [OP_W-1:0] OP_INDIRECT_LOAD_DEC    = 5'h10;
  localparam logic [OP_W-1:0] OP_DISPLACED_LOAD       = 5'h11;
  localparam logic [OP_W-1:0] OP_DIRECT_LOAD          = 5'h12;
  localparam logic [OP_W-1:0] OP_INDIRECT_STORE       = 5'h13;
  localparam logic [OP_W-1:0] OP_INDIRECT_STORE_INC   = 5'h14;
  localparam logic [OP_W-1:0] OP_INDIRECT_STORE_DEC   = 5'h15;
  localparam logic [OP_W-1:0] OP_DISPLACED_STORE      = 5'h16;
  localparam logic [OP_W-1:0] OP_DIRECT_STORE         = 5'h17;

  typedef enum logic [1:0] {
    CFE_IDLE = 2'b01,
    CFE_MEM  = 2'b10
  } cfe_state_t;

endpackage : cfe_pkg

// >>> src/cfe_exec.sv
module cfe_exec (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      op_valid,
  input  wire logic [cfe_pkg::OP_W-1:0]  op_code,
  input  wire logic [cfe_pkg::SEL_W-1:0] dst_sel,
  input  wire logic [cfe_pkg::SEL_W-1:0] src_sel,
  input  wire logic [2:0]                bit_sel,
  input  wire logic [1:0]                ptr_sel,
  input  wire logic [cfe_pkg::DISP_W-1:0] disp,
  input  wire logic [7:0]                imm,
  input  wire logic [cfe_pkg::ADDR_W-1:0] addr_k,
  input  wire logic [7:0]                mem_rdata,
  input  wire logic [cfe_pkg::SEL_W-1:0] peek_sel,
  output logic                           busy_reg,
  output logic                           done_reg,
  output logic                           illegal_reg,
  output logic [7:0]                     status_reg,
  output logic [cfe_pkg::ADDR_W-1:0]     mem_addr_reg,
  output logic [7:0]                     mem_wdata_reg,
  output logic                           mem_we_reg,
  output logic                           mem_re_reg,
  output logic [7:0]                     peek_data_reg
);

  cfe_pkg::cfe_state_t                  state_reg;
  cfe_pkg::cfe_state_t                  state_next;
  logic [7:0]                           rf_reg [0:cfe_pkg::REG_COUNT-1];
  logic [7:0]                           rf_next [0:cfe_pkg::REG_COUNT-1];
  logic [7:0]                           status_next;
  logic [cfe_pkg::ADDR_W-1:0]           mem_addr_next;
  logic [7:0]                           mem_wdata_next;
  logic                                 mem_we_next;
  logic                                 mem_re_next;
  logic                                 busy_next;
  logic                                 done_next;
  logic                                 illegal_next;
  logic [7:0]                           peek_data_next;
  logic [cfe_pkg::SEL_W-1:0]            load_dst_reg;
  logic [cfe_pkg::SEL_W-1:0]            load_dst_next;

  // Low byte index of a pointer pair; high byte is the next index
  function automatic logic [cfe_pkg::SEL_W-1:0] ptr_lo(
    input logic [1:0] sel
  );
    case (sel)
      cfe_pkg::PTR_X: ptr_lo = cfe_pkg::PTR_X_LO;
      cfe_pkg::PTR_Y: ptr_lo = cfe_pkg::PTR_Y_LO;
      default:        ptr_lo = cfe_pkg::PTR_Z_LO;
    endcase
  endfunction : ptr_lo

  function automatic logic [cfe_pkg::SEL_W-1:0] pair_hi(
    input logic [cfe_pkg::SEL_W-1:0] lo
  );
    pair_hi = {lo[cfe_pkg::SEL_W-1:1], 1'b1};
  endfunction : pair_hi

  function automatic logic [cfe_pkg::SEL_W-1:0] pair_lo(
    input logic [cfe_pkg::SEL_W-1:0] sel
  );
    pair_lo = {sel[cfe_pkg::SEL_W-1:1], 1'b0};
  endfunction : pair_lo

  // Memory operations that return data to the register file
  function automatic logic is_load(
    input logic [cfe_pkg::OP_W-1:0] op
  );
    case (op)
      cfe_pkg::OP_INDIRECT_LOAD,
      cfe_pkg::OP_INDIRECT_LOAD_INC,
      cfe_pkg::OP_INDIRECT_LOAD_DEC,
      cfe_pkg::OP_DISPLACED_LOAD,
      cfe_pkg::OP_DIRECT_LOAD: is_load = 1'b1;
      default:                 is_load = 1'b0;
    endcase
  endfunction : is_load

  // Pointer bumped after the access
  function automatic logic is_post_inc(
    input logic [cfe_pkg::OP_W-1:0] op
  );
    is_post_inc = (op == cfe_pkg::OP_INDIRECT_LOAD_INC) ||
                  (op == cfe_pkg::OP_INDIRECT_STORE_INC);
  endfunction : is_post_inc

  // Pointer dropped before the access
  function automatic logic is_pre_dec(
    input logic [cfe_pkg::OP_W-1:0] op
  );
    is_pre_dec = (op == cfe_pkg::OP_INDIRECT_LOAD_DEC) ||
                 (op == cfe_pkg::OP_INDIRECT_STORE_DEC);
  endfunction : is_pre_dec

  logic [cfe_pkg::SEL_W-1:0]  p_lo;
  logic [cfe_pkg::ADDR_W-1:0] p_cur;
  logic [cfe_pkg::ADDR_W-1:0] p_inc;
  logic [cfe_pkg::ADDR_W-1:0] p_dec;
  logic [cfe_pkg::ADDR_W-1:0] p_disp;
  logic                       ptr_ok;
  logic                       disp_ok;

  always_comb begin
    p_lo    = ptr_lo(ptr_sel);
    p_cur   = {rf_reg[pair_hi(p_lo)], rf_reg[p_lo]};
    // Full 16-bit sum so the carry reaches the high byte
    p_inc   = p_cur + cfe_pkg::PTR_STEP;
    p_dec   = p_cur - cfe_pkg::PTR_STEP;
    p_disp  = p_cur + {{(cfe_pkg::ADDR_W-cfe_pkg::DISP_W){1'b0}}, disp};
    ptr_ok  = (ptr_sel != 2'h3);
    // Displacement exists only on the second and third pairs
    disp_ok = (ptr_sel == cfe_pkg::PTR_Y) || (ptr_sel == cfe_pkg::PTR_Z);
  end

  always_comb begin
    state_next     = state_reg;
    rf_next        = rf_reg;
    status_next    = status_reg;
    mem_addr_next  = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    mem_we_next    = 1'b0;
    mem_re_next    = 1'b0;
    busy_next      = 1'b0;
    done_next      = 1'b0;
    illegal_next   = 1'b0;
    load_dst_next  = load_dst_reg;
    case (state_reg)
      cfe_pkg::CFE_IDLE: begin
        if (op_valid) begin
          done_next = 1'b1;
          case (op_code)
            cfe_pkg::OP_NOP: begin
            end
            cfe_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
              status_next[cfe_pkg::FLAG_T] = rf_reg[src_sel][bit_sel];
            end
            cfe_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
              rf_next[dst_sel][bit_sel] = status_reg[cfe_pkg::FLAG_T];
            end
            cfe_pkg::OP_FLAG_SET: begin
              status_next[bit_sel] = 1'b1;
            end
            cfe_pkg::OP_FLAG_CLEAR: begin
              status_next[bit_sel] = 1'b0;
            end
            cfe_pkg::OP_SET_SIGN_FLAG: begin
              status_next[cfe_pkg::FLAG_S] = 1'b1;
            end
            cfe_pkg::OP_CLEAR_SIGN_FLAG: begin
              status_next[cfe_pkg::FLAG_S] = 1'b0;
            end
            cfe_pkg::OP_SET_OVERFLOW: begin
              status_next[cfe_pkg::FLAG_V] = 1'b1;
            end
            cfe_pkg::OP_CLEAR_OVERFLOW: begin
              status_next[cfe_pkg::FLAG_V] = 1'b0;
            end
            cfe_pkg::OP_SET_HALF_CARRY: begin
              status_next[cfe_pkg::FLAG_H] = 1'b1;
            end
            cfe_pkg::OP_CLEAR_HALF_CARRY: begin
              status_next[cfe_pkg::FLAG_H] = 1'b0;
            end
            cfe_pkg::OP_REGISTER_MOVE: begin
              rf_next[dst_sel] = rf_reg[src_sel];
            end
            cfe_pkg::OP_REGISTER_PAIR_COPY: begin
              rf_next[pair_lo(dst_sel)] = rf_reg[pair_lo(src_sel)];
              rf_next[pair_hi(dst_sel)] = rf_reg[pair_hi(src_sel)];
            end
            cfe_pkg::OP_IMMEDIATE_LOAD: begin
              rf_next[dst_sel] = imm;
            end
            cfe_pkg::OP_INDIRECT_LOAD,
            cfe_pkg::OP_INDIRECT_LOAD_INC,
            cfe_pkg::OP_INDIRECT_LOAD_DEC,
            cfe_pkg::OP_INDIRECT_STORE,
            cfe_pkg::OP_INDIRECT_STORE_INC,
            cfe_pkg::OP_INDIRECT_STORE_DEC: begin
              if (ptr_ok) begin
                done_next      = 1'b0;
                busy_next      = 1'b1;
                state_next     = cfe_pkg::CFE_MEM;
                load_dst_next  = dst_sel;
                mem_wdata_next = rf_reg[src_sel];
                mem_addr_next  = p_cur;
                if (is_post_inc(op_code)) begin
                  // Access the old value, keep the bumped one
                  rf_next[p_lo]          = p_inc[7:0];
                  rf_next[pair_hi(p_lo)] = p_inc[15:8];
                end
                if (is_pre_dec(op_code)) begin
                  mem_addr_next          = p_dec;
                  rf_next[p_lo]          = p_dec[7:0];
                  rf_next[pair_hi(p_lo)] = p_dec[15:8];
                end
                if (is_load(op_code)) begin
                  mem_re_next = 1'b1;
                end else begin
                  mem_we_next = 1'b1;
                end
              end else begin
                illegal_next = 1'b1;
              end
            end
            cfe_pkg::OP_DISPLACED_LOAD,
            cfe_pkg::OP_DISPLACED_STORE: begin
              if (disp_ok) begin
                done_next      = 1'b0;
                busy_next      = 1'b1;
                state_next     = cfe_pkg::CFE_MEM;
                load_dst_next  = dst_sel;
                mem_wdata_next = rf_reg[src_sel];
                mem_addr_next  = p_disp;
                if (is_load(op_code)) begin
                  mem_re_next = 1'b1;
                end else begin
                  mem_we_next = 1'b1;
                end
              end else begin
                illegal_next = 1'b1;
              end
            end
            cfe_pkg::OP_DIRECT_LOAD,
            cfe_pkg::OP_DIRECT_STORE: begin
              done_next      = 1'b0;
              busy_next      = 1'b1;
              state_next     = cfe_pkg::CFE_MEM;
              load_dst_next  = dst_sel;
              mem_wdata_next = rf_reg[src_sel];
              mem_addr_next  = addr_k;
              if (is_load(op_code)) begin
                mem_re_next = 1'b1;
              end else begin
                mem_we_next = 1'b1;
              end
            end
            default: begin
              illegal_next = 1'b1;
            end
          endcase
        end
      end
      cfe_pkg::CFE_MEM: begin
        // Second cycle: capture read data, close the access
        // Requests seen in this cycle are dropped, not queued
        if (mem_re_reg) begin
          rf_next[load_dst_reg] = mem_rdata;
        end
        done_next  = 1'b1;
        state_next = cfe_pkg::CFE_IDLE;
      end
      default: begin
        state_next = cfe_pkg::CFE_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg     <= cfe_pkg::CFE_IDLE;
      status_reg    <= cfe_pkg::STATUS_RESET;
      mem_addr_reg  <= cfe_pkg::ADDR_RESET;
      mem_wdata_reg <= cfe_pkg::REG_RESET;
      mem_we_reg    <= 1'b0;
      mem_re_reg    <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      load_dst_reg  <= '0;
      for (int i = 0; i < cfe_pkg::REG_COUNT; i++) begin
        rf_reg[i] <= cfe_pkg::REG_RESET;
      end
    end else begin
      state_reg     <= state_next;
      status_reg    <= status_next;
      mem_addr_reg  <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
      mem_we_reg    <= mem_we_next;
      mem_re_reg    <= mem_re_next;
      busy_reg      <= busy_next;
      done_reg      <= done_next;
      illegal_reg   <= illegal_next;
      load_dst_reg  <= load_dst_next;
      for (int i = 0; i < cfe_pkg::REG_COUNT; i++) begin
        rf_reg[i] <= rf_next[i];
      end
    end
  end

  // Read-back path, independent of instruction flow
  always_comb begin
    peek_data_next = rf_reg[peek_sel];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      peek_data_reg <= cfe_pkg::REG_RESET;
    end else begin
      peek_data_reg <= peek_data_next;
    end
  end

endmodule : cfe_exec

// >>> tb/cfe_mem_model.sv
module cfe_mem_model (
  input  wire logic        core_clk,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic [7:0]       rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] last_reg = 8'h00;
  always @(posedge core_clk) begin
    if (we)
      mem[addr] <= wdata;
    if (re)
      last_reg <= mem[addr];
  end
  // Idle read lines show the inverse of the last byte
  assign rdata = re ? mem[addr] : ~last_reg;
endmodule : cfe_mem_model

// >>> tb/cfe_exec_properties.sv
module cfe_exec_properties (
  input wire logic                       core_clk,
  input wire logic                       rst,
  input wire logic                       op_valid,
  input wire logic [cfe_pkg::OP_W-1:0]   op_code,
  input wire logic [1:0]                 ptr_sel,
  input wire logic [cfe_pkg::ADDR_W-1:0] addr_k,
  input wire logic                       busy_reg,
  input wire logic                       done_reg,
  input wire logic [7:0]                 status_reg,
  input wire logic [cfe_pkg::ADDR_W-1:0] mem_addr_reg,
  input wire logic                       mem_we_reg,
  input wire logic                       mem_re_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = op_valid && !busy_reg;
  property p_flag(logic [4:0] op, int b, logic v);
    take && op_code == op |=> done_reg && status_reg[b] == v &&
      ((status_reg ^ $past(status_reg)) & ~(8'h01 << b)) == 8'h00;
  endproperty
  chk_sign_set:
    assert property (p_flag(cfe_pkg::OP_SET_SIGN_FLAG, cfe_pkg::FLAG_S,
      1'b1)) else $error("sign set wrong");
  chk_sign_clear:
    assert property (p_flag(cfe_pkg::OP_CLEAR_SIGN_FLAG, cfe_pkg::FLAG_S,
      1'b0)) else $error("sign clear wrong");
  chk_ovf_set:
    assert property (p_flag(cfe_pkg::OP_SET_OVERFLOW, cfe_pkg::FLAG_V,
      1'b1)) else $error("overflow set wrong");
  chk_ovf_clear:
    assert property (p_flag(cfe_pkg::OP_CLEAR_OVERFLOW, cfe_pkg::FLAG_V,
      1'b0)) else $error("overflow clear wrong");
  chk_half_set:
    assert property (p_flag(cfe_pkg::OP_SET_HALF_CARRY, cfe_pkg::FLAG_H,
      1'b1)) else $error("half carry set wrong");
  chk_half_clear:
    assert property (p_flag(cfe_pkg::OP_CLEAR_HALF_CARRY, cfe_pkg::FLAG_H,
      1'b0)) else $error("half carry clear wrong");
  chk_mem_two_cycle:
    assert property (take && op_code == cfe_pkg::OP_INDIRECT_LOAD_INC &&
      ptr_sel != 2'h3 |=> busy_reg && mem_re_reg ##1 done_reg && !busy_reg)
      else $error("post increment load timing wrong");
  chk_busy_done:
    assert property (busy_reg |=> done_reg && !busy_reg)
      else $error("memory cycle not closed");
  chk_strobe_busy:
    assert property ((mem_re_reg || mem_we_reg) |-> busy_reg &&
      !(mem_re_reg && mem_we_reg)) else $error("memory strobe wrong");
  chk_addr_hold:
    assert property (!busy_reg |-> $stable(mem_addr_reg))
      else $error("memory address moved");
  chk_direct_addr:
    assert property (take && op_code == cfe_pkg::OP_DIRECT_LOAD |=>
      mem_re_reg && mem_addr_reg == $past(addr_k))
      else $error("direct load address wrong");
  cov_read: cover property (mem_re_reg);
  cov_write: cover property (mem_we_reg);
  cov_done: cover property (busy_reg ##1 done_reg);
endmodule : cfe_exec_properties

bind cfe_exec cfe_exec_properties u_chk (.core_clk, .rst, .op_valid,
  .op_code, .ptr_sel, .addr_k, .busy_reg, .done_reg, .status_reg,
  .mem_addr_reg, .mem_we_reg, .mem_re_reg);

// >>> tb/tb_cfe_exec.sv
module tb_cfe_exec;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst, op_valid, busy_reg, done_reg, illegal_reg, mem_we_reg;
  logic mem_re_reg;
  logic [4:0]  op_code, dst_sel, src_sel, peek_sel;
  logic [2:0]  bit_sel;
  logic [1:0]  ptr_sel;
  logic [5:0]  disp;
  logic [7:0]  imm, mem_rdata, status_reg, mem_wdata_reg, peek_data_reg;
  logic [15:0] addr_k, mem_addr_reg;
  int          num_errors = 0;
  int          check_count = 0;

  cfe_exec uut (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .dst_sel(dst_sel), .src_sel(src_sel),
    .bit_sel(bit_sel), .ptr_sel(ptr_sel), .disp(disp), .imm(imm),
    .addr_k(addr_k), .mem_rdata(mem_rdata), .peek_sel(peek_sel),
    .busy_reg(busy_reg), .done_reg(done_reg), .illegal_reg(illegal_reg),
    .status_reg(status_reg), .mem_addr_reg(mem_addr_reg),
    .mem_wdata_reg(mem_wdata_reg), .mem_we_reg(mem_we_reg),
    .mem_re_reg(mem_re_reg), .peek_data_reg(peek_data_reg));
  cfe_mem_model mdl (.core_clk(core_clk), .addr(mem_addr_reg),
    .wdata(mem_wdata_reg), .we(mem_we_reg), .re(mem_re_reg),
    .rdata(mem_rdata));

  initial forever #20 core_clk = ~core_clk;

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h got %h", n, e, g);
    end
  endtask : chk

  // Issue one op and count cycles up to done
  task automatic run(input logic [4:0] c, input logic [4:0] d,
                     input logic [4:0] s, input logic [15:0] cyc);
    logic [15:0] n;
    op_code = c;
    dst_sel = d;
    src_sel = s;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
    n = 16'h0001;
    while (done_reg !== 1'b1 && n < 16'h0005) begin
      @(negedge core_clk);
      n++;
    end
    chk("cycles", cyc, n);
    // Idle cycle so the next request starts from a low strobe
    @(negedge core_clk);
  endtask : run

  task automatic peek(input logic [4:0] r, input logic [7:0] e);
    peek_sel = r;
    @(negedge core_clk);
    @(negedge core_clk);
    chk("reg", {8'h00, e}, {8'h00, peek_data_reg});
  endtask : peek

  task automatic load_imm(input logic [4:0] r, input logic [7:0] v);
    imm = v;
    run(cfe_pkg::OP_IMMEDIATE_LOAD, r, 5'h00, 16'h0001);
  endtask : load_imm

  task automatic t_flags;
    logic [4:0] ops [6] = '{cfe_pkg::OP_SET_SIGN_FLAG,
      cfe_pkg::OP_SET_OVERFLOW, cfe_pkg::OP_SET_HALF_CARRY,
      cfe_pkg::OP_CLEAR_SIGN_FLAG, cfe_pkg::OP_CLEAR_OVERFLOW,
      cfe_pkg::OP_CLEAR_HALF_CARRY};
    logic [7:0] ex [6] = '{8'h10, 8'h18, 8'h38, 8'h28, 8'h20, 8'h00};
    for (int i = 0; i < 6; i++) begin
      run(ops[i], 5'h00, 5'h00, 16'h0001);
      chk("status", {8'h00, ex[i]}, {8'h00, status_reg});
    end
    $display("test flags done");
  endtask : t_flags

  task automatic t_bits;
    load_imm(5'h05, 8'ha5);
    bit_sel = 3'h2;
    run(cfe_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h05, 16'h0001);
    chk("status", 16'h0040, {8'h00, status_reg});
    bit_sel = 3'h7;
    run(cfe_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h06, 5'h00, 16'h0001);
    chk("status", 16'h0040, {8'h00, status_reg});
    peek(5'h06, 8'h80);
    bit_sel = 3'h1;
    run(cfe_pkg::OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h05, 16'h0001);
    chk("status", 16'h0000, {8'h00, status_reg});
    run(cfe_pkg::OP_REGISTER_MOVE, 5'h0a, 5'h05, 16'h0001);
    peek(5'h0a, 8'ha5);
    $display("test bits done");
  endtask : t_bits

  task automatic t_mem;
    load_imm(cfe_pkg::PTR_X_LO, 8'hff);
    load_imm(cfe_pkg::PTR_X_LO + 5'h01, 8'h00);
    ptr_sel = cfe_pkg::PTR_X;
    run(cfe_pkg::OP_INDIRECT_STORE_INC, 5'h00, 5'h05, 16'h0002);
    chk("mem", 16'h00a5, {8'h00, mdl.mem[16'h00ff]});
    peek(cfe_pkg::PTR_X_LO + 5'h01, 8'h01);
    run(cfe_pkg::OP_INDIRECT_LOAD_DEC, 5'h07, 5'h00, 16'h0002);
    peek(5'h07, 8'ha5);
    peek(cfe_pkg::PTR_X_LO + 5'h01, 8'h00);
    load_imm(cfe_pkg::PTR_Y_LO, 8'h00);
    load_imm(cfe_pkg::PTR_Y_LO + 5'h01, 8'h01);
    ptr_sel = cfe_pkg::PTR_Y;
    run(cfe_pkg::OP_INDIRECT_STORE_DEC, 5'h00, 5'h06, 16'h0002);
    chk("mem", 16'h0080, {8'h00, mdl.mem[16'h00ff]});
    run(cfe_pkg::OP_INDIRECT_LOAD_INC, 5'h0b, 5'h00, 16'h0002);
    peek(5'h0b, 8'h80);
    disp = 6'h3f;
    run(cfe_pkg::OP_DISPLACED_STORE, 5'h00, 5'h07, 16'h0002);
    chk("mem", 16'h00a5, {8'h00, mdl.mem[16'h013f]});
    run(cfe_pkg::OP_DISPLACED_LOAD, 5'h08, 5'h00, 16'h0002);
    peek(5'h08, 8'ha5);
    peek(cfe_pkg::PTR_Y_LO + 5'h01, 8'h01);
    addr_k = 16'h013f;
    run(cfe_pkg::OP_DIRECT_LOAD, 5'h09, 5'h00, 16'h0002);
    peek(5'h09, 8'ha5);
    addr_k = 16'h0100;
    run(cfe_pkg::OP_DIRECT_STORE, 5'h00, 5'h06, 16'h0002);
    run(cfe_pkg::OP_INDIRECT_LOAD, 5'h0c, 5'h00, 16'h0002);
    peek(5'h0c, 8'h80);
    $display("test memory done");
  endtask : t_mem

  // Generic flag ops, pair copy, plain store, refused displacement
  task automatic t_misc;
    bit_sel = 3'h6;
    run(cfe_pkg::OP_FLAG_SET, 5'h00, 5'h00, 16'h0001);
    chk("status", 16'h0040, {8'h00, status_reg});
    bit_sel = 3'h0;
    run(cfe_pkg::OP_TRANSFER_FLAG_TO_BIT, 5'h0d, 5'h00, 16'h0001);
    peek(5'h0d, 8'h01);
    bit_sel = 3'h6;
    run(cfe_pkg::OP_FLAG_CLEAR, 5'h00, 5'h00, 16'h0001);
    chk("status", 16'h0000, {8'h00, status_reg});
    run(cfe_pkg::OP_NOP, 5'h00, 5'h00, 16'h0001);
    run(cfe_pkg::OP_REGISTER_PAIR_COPY, 5'h0f, 5'h0b, 16'h0001);
    peek(5'h0e, 8'ha5);
    peek(5'h0f, 8'h80);
    ptr_sel = cfe_pkg::PTR_X;
    run(cfe_pkg::OP_INDIRECT_STORE, 5'h00, 5'h0d, 16'h0002);
    chk("mem", 16'h0001, {8'h00, mdl.mem[16'h00ff]});
    peek(cfe_pkg::PTR_X_LO, 8'hff);
    op_code  = cfe_pkg::OP_DISPLACED_LOAD;
    dst_sel  = 5'h0e;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
    chk("illegal", 16'h0001, {15'h0000, illegal_reg});
    @(negedge core_clk);
    chk("illegal", 16'h0000, {15'h0000, illegal_reg});
    peek(5'h0e, 8'ha5);
    $display("test misc done");
  endtask : t_misc

  initial begin
    {op_valid, op_code, dst_sel, src_sel, bit_sel, ptr_sel} = '0;
    {disp, imm, addr_k, peek_sel} = '0;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_flags;
    t_bits;
    t_mem;
    t_misc;
    close_out;
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    close_out;
  end
endmodule : tb_cfe_exec
